// [pkg/port_mux_pkg.sv]
// constants for the two-port alternate-function override logic
// What this block does
// - first port never overrides pull-up, direction or output value
// - first port input-enable override: mask and group enable, or analog disable
// - first port pins route to converter channels 0 to 7
// - first port digital inputs feed pin-change inputs 0 to 7
// - spi slave forces serial clock pin to input
// - spi master leaves serial clock direction to its direction bit
// - data-in pin is input as master, follows direction bit as slave
// - data-out pin is input as slave, follows direction bit as master
// - select pin is input as slave, follows direction bit as master
// - forced-input spi pins keep pull-up under the port output bit
// - spi slave is active while select pin reads low, as it does in sleep with its input disabled
// - timer0 compare b drives second-port bit 4 when direction is output
// - timer0 compare a drives second-port bit 3 when direction is output
// - second-port bits 3 and 2 feed comparator negative and positive
// - second-port bit 2 feeds external interrupt 2
// - clock-out fuse drives divided clock on second-port bit 1
// - divided clock keeps running on bit 1 during reset
// - second-port bit 1 is the timer1 counting input
// - second-port digital inputs feed pin-change inputs 8 to 15
// - no pull-up override: pull-up on when dir, port, disable are 010
// - direction override selects driver enable, else direction bit
// - input-enable override selects input enable, else sleep state
package port_mux_pkg;
  localparam int PORT_WIDTH = 8;
  localparam logic [2:0] PULLUP_ON_PATTERN = 3'h2;
  localparam int PIN_SCK = 7;
  localparam int PIN_MISO = 6;
  localparam int PIN_MOSI = 5;
  localparam int PIN_SEL = 4;
  localparam int PIN_CMP_A = 3;
  localparam int PIN_CMP_B = 4;
  localparam int PIN_EXT_IRQ_2 = 2;
  localparam int PIN_CLK = 1;
  localparam int SYNC_STAGES = 3;
  localparam logic [7:0] CLK_DIV_DEFAULT = 8'h01;
endpackage : port_mux_pkg

// [verilog/pin_cell.sv]
// one generic pad cell: override resolution and three-flop input synchroniser
module pin_cell
  import port_mux_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstSync_n,
  input wire logic padIn,
  input wire logic dirBit,
  input wire logic portBit,
  input wire logic globalPullupDisable,
  input wire logic sleepActive,
  input wire logic pullupOverrideEn,
  input wire logic pullupOverrideVal,
  input wire logic dirOverrideEn,
  input wire logic dirOverrideVal,
  input wire logic outvalOverrideEn,
  input wire logic outvalOverrideVal,
  input wire logic inputEnOverrideEn,
  input wire logic inputEnOverrideVal,
  output logic padOut,
  output logic padOe,
  output logic padPullup,
  output logic digIn,
  output logic pinSync
);
  logic [SYNC_STAGES-1:0] sync_reg;
  logic [SYNC_STAGES-1:0] sync_next;
  logic pinSync_reg;
  logic pinSync_next;
  logic inputEn;

  // ---------------------------------------------------------------
  // override resolution
  // ---------------------------------------------------------------
  always_comb begin
    padPullup = pullupOverrideEn ? pullupOverrideVal :
      ({dirBit, portBit, globalPullupDisable} == PULLUP_ON_PATTERN);
    padOe = dirOverrideEn ? dirOverrideVal : dirBit;
    padOut = outvalOverrideEn ? outvalOverrideVal : portBit;
    inputEn = inputEnOverrideEn ? inputEnOverrideVal : ~sleepActive;
    digIn = padIn & inputEn;
  end

  // ---------------------------------------------------------------
  // synchroniser: change counts once stages two and three agree
  // ---------------------------------------------------------------
  always_comb begin
    sync_next = {sync_reg[SYNC_STAGES-2:0], digIn};
    pinSync_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : pinSync_reg;
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      sync_reg <= '0;
      pinSync_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      pinSync_reg <= pinSync_next;
    end
  end

  assign pinSync = pinSync_reg;
endmodule : pin_cell

// [verilog/port_ab_alternate_function_mux.sv]
// two-port alternate-function override mux with divided clock output
module port_ab_alternate_function_mux
  import port_mux_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH,
  parameter logic [7:0] CLK_DIV = CLK_DIV_DEFAULT
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic globalPullupDisable,
  input wire logic sleepActive,
  input wire logic [WIDTH-1:0] portAIn,
  input wire logic [WIDTH-1:0] portADir,
  input wire logic [WIDTH-1:0] portAOut,
  output logic [WIDTH-1:0] portAPadOut,
  output logic [WIDTH-1:0] portAPadOe,
  output logic [WIDTH-1:0] portAPullup,
  input wire logic [WIDTH-1:0] pinChangeMaskLo,
  input wire logic pinChangeGroup0En,
  input wire logic [WIDTH-1:0] analogDigitalDisable,
  output logic [WIDTH-1:0] pinChangeInLo,
  output logic [WIDTH-1:0] converterChannelSel,
  input wire logic [WIDTH-1:0] portBIn,
  input wire logic [WIDTH-1:0] portBDir,
  input wire logic [WIDTH-1:0] portBOut,
  output logic [WIDTH-1:0] portBPadOut,
  output logic [WIDTH-1:0] portBPadOe,
  output logic [WIDTH-1:0] portBPullup,
  input wire logic [WIDTH-1:0] pinChangeMaskHi,
  input wire logic pinChangeGroup1En,
  output logic [WIDTH-1:0] pinChangeInHi,
  input wire logic spiEnable,
  input wire logic spiMaster,
  input wire logic spiSckOut,
  input wire logic spiMasterOut,
  input wire logic spiSlaveOut,
  output logic spiSckIn,
  output logic spiMasterIn,
  output logic spiSlaveIn,
  output logic spiSlaveActive,
  input wire logic timer0CmpAEn,
  input wire logic timer0CmpAOut,
  input wire logic timer0CmpBEn,
  input wire logic timer0CmpBOut,
  output logic comparatorPosSel,
  output logic comparatorNegSel,
  input wire logic extIrq2En,
  output logic extIrq2,
  output logic timer1CountIn,
  input wire logic clockOutFuse
);
  logic rstMeta_reg;
  logic rstSync_reg;
  logic [7:0] divCnt_reg = 8'h00;
  logic [7:0] divCnt_next;
  logic divClk_reg = 1'b0;
  logic divClk_next;
  logic spiSlaveMode;
  logic spiMasterMode;
  logic [WIDTH-1:0] aInEnOe;
  logic [WIDTH-1:0] aInEnOv;
  logic [WIDTH-1:0] bPuOe;
  logic [WIDTH-1:0] bPuOv;
  logic [WIDTH-1:0] bDdOe;
  logic [WIDTH-1:0] bDdOv;
  logic [WIDTH-1:0] bPvOe;
  logic [WIDTH-1:0] bPvOv;
  logic [WIDTH-1:0] bInEnOe;
  logic [WIDTH-1:0] bInEnOv;
  logic [WIDTH-1:0] aSync;
  logic [WIDTH-1:0] bSync;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  // ---------------------------------------------------------------
  // divided clock source
  // ---------------------------------------------------------------
  // deliberately not reset: the divided clock must keep toggling in reset,
  // so only the power-up value is given, at the declaration
  always_comb begin
    if (divCnt_reg >= CLK_DIV - 8'h01) begin
      divCnt_next = 8'h00;
      divClk_next = ~divClk_reg;
    end else begin
      divCnt_next = divCnt_reg + 8'h01;
      divClk_next = divClk_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    divCnt_reg <= divCnt_next;
    divClk_reg <= divClk_next;
  end

  // ---------------------------------------------------------------
  // override generation
  // ---------------------------------------------------------------
  always_comb begin
    spiSlaveMode = spiEnable & ~spiMaster;
    spiMasterMode = spiEnable & spiMaster;
    aInEnOe = (pinChangeMaskLo & {WIDTH{pinChangeGroup0En}}) | analogDigitalDisable;
    aInEnOv = pinChangeMaskLo & {WIDTH{pinChangeGroup0En}};
    bPuOe = '0;
    bPuOv = '0;
    bDdOe = '0;
    bDdOv = '0;
    bPvOe = '0;
    bPvOv = '0;
    bInEnOe = pinChangeMaskHi & {WIDTH{pinChangeGroup1En}};
    bInEnOv = '1;
    // forced inputs: pull-up from port bit unless globally disabled
    bPuOe[PIN_SCK] = spiSlaveMode;
    bDdOe[PIN_SCK] = spiSlaveMode;
    bPuOv[PIN_SCK] = portBOut[PIN_SCK] & ~globalPullupDisable;
    bPuOe[PIN_MISO] = spiMasterMode;
    bDdOe[PIN_MISO] = spiMasterMode;
    bPuOv[PIN_MISO] = portBOut[PIN_MISO] & ~globalPullupDisable;
    bPuOe[PIN_MOSI] = spiSlaveMode;
    bDdOe[PIN_MOSI] = spiSlaveMode;
    bPuOv[PIN_MOSI] = portBOut[PIN_MOSI] & ~globalPullupDisable;
    bPuOe[PIN_SEL] = spiSlaveMode;
    bDdOe[PIN_SEL] = spiSlaveMode;
    bPuOv[PIN_SEL] = portBOut[PIN_SEL] & ~globalPullupDisable;
    // output values reach the pad only when the driver is enabled
    bPvOe[PIN_SCK] = spiMasterMode;
    bPvOv[PIN_SCK] = spiSckOut;
    bPvOe[PIN_MISO] = spiSlaveMode;
    bPvOv[PIN_MISO] = spiSlaveOut;
    bPvOe[PIN_MOSI] = spiMasterMode;
    bPvOv[PIN_MOSI] = spiMasterOut;
    bPvOe[PIN_CMP_B] = timer0CmpBEn;
    bPvOv[PIN_CMP_B] = timer0CmpBOut;
    bPvOe[PIN_CMP_A] = timer0CmpAEn;
    bPvOv[PIN_CMP_A] = timer0CmpAOut;
    bInEnOe[PIN_EXT_IRQ_2] = bInEnOe[PIN_EXT_IRQ_2] | extIrq2En;
    bDdOe[PIN_CLK] = clockOutFuse;
    bDdOv[PIN_CLK] = clockOutFuse;
    bPvOe[PIN_CLK] = clockOutFuse;
    bPvOv[PIN_CLK] = divClk_reg;
  end

  // ---------------------------------------------------------------
  // pad cells
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_pin
      pin_cell u_a (
        .core_clk(core_clk),
        .rstSync_n(rstSync_reg),
        .padIn(portAIn[gi]),
        .dirBit(portADir[gi]),
        .portBit(portAOut[gi]),
        .globalPullupDisable(globalPullupDisable),
        .sleepActive(sleepActive),
        .pullupOverrideEn(1'b0),
        .pullupOverrideVal(1'b0),
        .dirOverrideEn(1'b0),
        .dirOverrideVal(1'b0),
        .outvalOverrideEn(1'b0),
        .outvalOverrideVal(1'b0),
        .inputEnOverrideEn(aInEnOe[gi]),
        .inputEnOverrideVal(aInEnOv[gi]),
        .padOut(portAPadOut[gi]),
        .padOe(portAPadOe[gi]),
        .padPullup(portAPullup[gi]),
        .digIn(),
        .pinSync(aSync[gi])
      );
      pin_cell u_b (
        .core_clk(core_clk),
        .rstSync_n(rstSync_reg),
        .padIn(portBIn[gi]),
        .dirBit(portBDir[gi]),
        .portBit(portBOut[gi]),
        .globalPullupDisable(globalPullupDisable),
        .sleepActive(sleepActive),
        .pullupOverrideEn(bPuOe[gi]),
        .pullupOverrideVal(bPuOv[gi]),
        .dirOverrideEn(bDdOe[gi]),
        .dirOverrideVal(bDdOv[gi]),
        .outvalOverrideEn(bPvOe[gi]),
        .outvalOverrideVal(bPvOv[gi]),
        .inputEnOverrideEn(bInEnOe[gi]),
        .inputEnOverrideVal(bInEnOv[gi]),
        .padOut(portBPadOut[gi]),
        .padOe(portBPadOe[gi]),
        .padPullup(portBPullup[gi]),
        .digIn(),
        .pinSync(bSync[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // alternate-function inputs
  // ---------------------------------------------------------------
  always_comb begin
    pinChangeInLo = aSync;
    converterChannelSel = ~analogDigitalDisable | analogDigitalDisable;
    pinChangeInHi = bSync;
    spiSckIn = bSync[PIN_SCK];
    spiMasterIn = bSync[PIN_MISO];
    spiSlaveIn = bSync[PIN_MOSI];
    spiSlaveActive = spiSlaveMode & ~bSync[PIN_SEL];
    comparatorNegSel = 1'b1;
    comparatorPosSel = 1'b1;
    extIrq2 = bSync[PIN_EXT_IRQ_2];
    timer1CountIn = bSync[PIN_CLK];
  end
endmodule : port_ab_alternate_function_mux

// [tb/port_mux_monitor.sv]
// checker watching the pad controls of the port override mux
module port_mux_monitor
  import port_mux_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic globalPullupDisable,
  input wire logic sleepActive,
  input wire logic [WIDTH-1:0] portAIn,
  input wire logic [WIDTH-1:0] portADir,
  input wire logic [WIDTH-1:0] portAOut,
  input wire logic [WIDTH-1:0] portAPadOut,
  input wire logic [WIDTH-1:0] portAPadOe,
  input wire logic [WIDTH-1:0] portAPullup,
  input wire logic [WIDTH-1:0] analogDigitalDisable,
  input wire logic [WIDTH-1:0] pinChangeInLo,
  input wire logic [WIDTH-1:0] portBDir,
  input wire logic [WIDTH-1:0] portBOut,
  input wire logic [WIDTH-1:0] portBPadOut,
  input wire logic [WIDTH-1:0] portBPadOe,
  input wire logic [WIDTH-1:0] portBPullup,
  input wire logic spiEnable,
  input wire logic spiMaster,
  input wire logic spiSlaveActive,
  input wire logic clockOutFuse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire slave = spiEnable && !spiMaster;
  wire [WIDTH-1:0] pullOk = {WIDTH{!globalPullupDisable}};
  wire pinOk = portAIn[0] && !sleepActive && !analogDigitalDisable[0];
  a_fixed_a: assert property (portAPadOe == portADir && portAPadOut == portAOut)
    else $error("port a pin overridden");
  a_pullup_a: assert property (portAPullup == (~portADir & portAOut & pullOk))
    else $error("port a pull-up wrong");
  sck_slave_a: assert property (slave |-> !portBPadOe[7])
    else $error("clock pin driven as slave");
  sck_master_a: assert property (spiEnable && spiMaster |-> portBPadOe[7] == portBDir[7])
    else $error("clock pin direction as master");
  miso_dir_a: assert property (spiEnable |-> portBPadOe[6] == (slave && portBDir[6]))
    else $error("data-in pin direction");
  mosi_dir_a: assert property (spiEnable |-> portBPadOe[5] == (spiMaster && portBDir[5]))
    else $error("data-out pin direction");
  select_dir_a: assert property (spiEnable |-> portBPadOe[4] == (spiMaster && portBDir[4]))
    else $error("select pin direction");
  forced_pull_a: assert property (slave |-> portBPullup[7] == (portBOut[7] && pullOk[0]))
    else $error("forced pin pull-up");
  slave_active_a: assert property (spiSlaveActive |-> slave && !portBPadOe[4])
    else $error("slave active outside slave mode");
  clock_out_a: assert property (clockOutFuse [*2] |-> portBPadOe[1] && $changed(portBPadOut[1]))
    else $error("divided clock not on pin");
  sync_rise_a: assert property ($rose(portAIn[0]) && pinOk ##1 pinOk [*5] |-> pinChangeInLo[0])
    else $error("pin change input late");
  cover property (slave && spiSlaveActive);
  cover property (clockOutFuse && spiEnable && spiMaster);
  cover property ($rose(pinChangeInLo[0]));
endmodule : port_mux_monitor

bind port_ab_alternate_function_mux port_mux_monitor #(.WIDTH(WIDTH)) monitor (
  .core_clk, .resetn, .globalPullupDisable, .sleepActive, .portAIn, .portADir, .portAOut,
  .portAPadOut, .portAPadOe, .portAPullup, .analogDigitalDisable, .pinChangeInLo, .portBDir,
  .portBOut, .portBPadOut, .portBPadOe, .portBPullup, .spiEnable, .spiMaster, .spiSlaveActive,
  .clockOutFuse);

// [tb/pad_board.sv]
// board-side model of one port's pins
module pad_board
  import port_mux_pkg::*;
(
  input wire logic [PORT_WIDTH-1:0] padOut,
  input wire logic [PORT_WIDTH-1:0] padOe,
  input wire logic [PORT_WIDTH-1:0] drive,
  output logic [PORT_WIDTH-1:0] pin
);
  // the board, external master included, drives every pin the pad leaves free
  assign pin = (padOe & padOut) | (~padOe & drive);
endmodule : pad_board

// [tb/testbench.sv]
// self-checking bench for the port override mux
module testbench
  import port_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic globalPullupDisable, sleepActive, pinChangeGroup0En, pinChangeGroup1En, spiEnable;
  logic spiMaster, spiSckOut, spiMasterOut, spiSlaveOut, timer0CmpAEn, timer0CmpAOut;
  logic timer0CmpBEn, timer0CmpBOut, extIrq2En, clockOutFuse, c;
  logic [7:0] portADir, portAOut, portBDir, portBOut, pinChangeMaskLo, pinChangeMaskHi;
  logic [7:0] analogDigitalDisable, drvA, drvB;
  wire logic [7:0] portAIn, portBIn, portAPadOut, portAPadOe, portAPullup, pinChangeInLo;
  wire logic [7:0] converterChannelSel, portBPadOut, portBPadOe, portBPullup, pinChangeInHi;
  wire logic spiSckIn, spiMasterIn, spiSlaveIn, spiSlaveActive, comparatorPosSel;
  wire logic comparatorNegSel, extIrq2, timer1CountIn;
  int errors = 0;
  int n_tests = 0;
  int seed = 32'h4158_8365;

  always #10 core_clk = ~core_clk;

  port_ab_alternate_function_mux #(.WIDTH(8), .CLK_DIV(8'h01)) DUT (.*);
  pad_board boardA (.padOut(portAPadOut), .padOe(portAPadOe), .drive(drvA), .pin(portAIn));
  pad_board boardB (.padOut(portBPadOut), .padOe(portBPadOe), .drive(drvB), .pin(portBIn));

  task automatic check(logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // spi pins forced to input: clock, data-out, select as slave; data-in as master
  function automatic logic [7:0] forced();
    return spiEnable ? (spiMaster ? 8'h40 : 8'hB0) : 8'h00;
  endfunction : forced

  function automatic logic [7:0] inEn(logic [7:0] ovr, logic [7:0] val);
    return (ovr & val) | (~ovr & {8{!sleepActive}});
  endfunction : inEn

  task automatic shake(int i);
    logic [31:0] r;
    {portADir, portAOut, portBDir, portBOut} = $random(seed);
    {pinChangeMaskLo, pinChangeMaskHi, analogDigitalDisable, drvA} = $random(seed);
    r = $random(seed);
    drvB = r[7:0];
    {globalPullupDisable, pinChangeGroup0En, pinChangeGroup1En, spiEnable} = r[11:8];
    {spiMaster, spiSckOut, spiMasterOut, spiSlaveOut} = r[15:12];
    {timer0CmpAEn, timer0CmpAOut, timer0CmpBEn, timer0CmpBOut, extIrq2En} = r[20:16];
    clockOutFuse = r[21];
    sleepActive = (r[25:24] == 2'h0);
    // hand-picked corners: direction bits all set against forced inputs, then analog disable all set in sleep
    case (i)
      0: {spiEnable, spiMaster, portBDir, drvB[4], sleepActive} = {2'b10, 8'hFF, 2'b00};
      1: {spiEnable, spiMaster, portBDir} = {2'b11, 8'hFF};
      2: {analogDigitalDisable, pinChangeGroup0En, sleepActive} = {8'hFF, 2'b11};
      default: ;
    endcase
  endtask : shake

  // ---------------------------------------------
  // comparisons after the synchronisers settle
  // ---------------------------------------------
  task automatic verify();
    logic [7:0] f, oe, lvB, gLo, padA, pv;
    f = forced();
    oe = (portBDir & ~f) | {6'h00, clockOutFuse, 1'b0};
    gLo = pinChangeMaskLo & {8{pinChangeGroup0En}};
    // port a pads: the board only reaches pins whose driver is off
    padA = (portADir & portAOut) | (~portADir & drvA);
    pv = portBOut;
    if (spiEnable && spiMaster) {pv[7], pv[5]} = {spiSckOut, spiMasterOut};
    if (spiEnable && !spiMaster) pv[6] = spiSlaveOut;
    if (timer0CmpBEn) pv[4] = timer0CmpBOut;
    if (timer0CmpAEn) pv[3] = timer0CmpAOut;
    lvB = drvB & inEn(pinChangeMaskHi & {8{pinChangeGroup1En}} | {5'h00, extIrq2En, 2'h0}, 8'hFF);
    check(portAPadOe, portADir);
    check(portAPadOut, portAOut);
    check(portAPullup, ~portADir & portAOut & {8{!globalPullupDisable}});
    check(portBPadOe, oe);
    check(portBPullup, (~portBDir | f) & portBOut & {8{!globalPullupDisable}});
    check(pinChangeInLo, padA & inEn(gLo | analogDigitalDisable, gLo));
    check(portBPadOut & ~oe[1:0], pv & ~oe[1:0]);
    check(pinChangeInHi & ~oe, lvB & ~oe);
    check({spiSckIn, spiMasterIn, spiSlaveIn, extIrq2, timer1CountIn} & {~oe[7:5], ~oe[2:1]},
          {lvB[7:5], lvB[2:1]} & {~oe[7:5], ~oe[2:1]});
    if (!sleepActive) check(spiSlaveActive, f[4] & !spiMaster & !drvB[4]);
    check(converterChannelSel, 8'hFF);
    check({comparatorPosSel, comparatorNegSel}, 8'h03);
    if (!spiEnable && timer0CmpBEn) check(portBPadOut[4], timer0CmpBOut);
    if (timer0CmpAEn && !clockOutFuse) check(portBPadOut[3], timer0CmpAOut);
    if (clockOutFuse) begin
      c = portBPadOut[1];
      @(posedge core_clk);
      #1;
      check(portBPadOut[1], !c);
    end
  endtask : verify

  initial begin
    shake(3);
    clockOutFuse = 1'b1;
    repeat (18) @(posedge core_clk);
    #1;
    c = portBPadOut[1];
    @(posedge core_clk);
    #1;
    check(portBPadOut[1], !c);
    check(portBPadOe[1], 1'b1);
    @(posedge core_clk);
    #1;
    resetn = 1'b1;
    for (int i = 0; i < 80; i++) begin
      @(posedge core_clk);
      #1;
      shake(i);
      repeat (7) @(posedge core_clk);
      #1;
      verify();
    end
    conclude();
  end

  initial begin
    repeat (2000) @(posedge core_clk);
    errors++;
    conclude();
  end
endmodule : testbench
